// ---- src/asbla_ctrl.sv ----
// Controller that drives an asynchronous 16-bit static memory through its pins.
// Assumes one 10 MHz clock; the memory has no clock and the read data pins are
// sampled through three flip-flops as they come from outside.
`timescale 1ns/100ps

// Operation
// - A write begins only by driving both select and write strobe low.
// - Write data stays stable around the edge that ends the write.
// - A strobe-controlled write lasts at least float delay plus data setup.
// - Write strobe stays high for the whole of a read.
// - The address is valid no later than select falling for a read.
// - The first access waits the settling time after power comes up.
module asbla_ctrl
(
  input  wire logic                          clk,
  input  wire logic                          reset_n,
  input  wire logic                          reqValid,
  output logic                               reqReady,
  input  wire logic                          reqWrite,
  input  wire logic [asbla_pkg::ADDR_W-1:0]  reqAddr,
  input  wire logic [asbla_pkg::DATA_W-1:0]  reqWdata,
  input  wire logic [1:0]                    reqByteEn,
  output logic                               rspValid,
  output logic [asbla_pkg::DATA_W-1:0]       rspRdata,
  output logic [asbla_pkg::ADDR_W-1:0]       memAddr,
  output logic                               chipSel_n,
  output logic                               outDrive_n,
  output logic                               writeStrobe_n,
  output logic                               low_byte_sel_n,
  output logic                               high_byte_sel_n,
  input  wire logic [asbla_pkg::DATA_W-1:0]  memDataIn,
  output logic [asbla_pkg::DATA_W-1:0]       memDataOut,
  output logic [1:0]                         memDataOe
);

  typedef struct packed {
    asbla_pkg::asbla_state_type        state;
    logic [asbla_pkg::CNT_W-1:0]       cnt;
    logic [asbla_pkg::ADDR_W-1:0]      addr;
    logic [asbla_pkg::DATA_W-1:0]      wdata;
    logic [1:0]                        laneEn;
    logic                              cs_n;
    logic                              oe_n;
    logic                              we_n;
    logic [1:0]                        dataOe;
    logic                              rspValid;
    logic [asbla_pkg::DATA_W-1:0]      rdata;
    logic [asbla_pkg::DATA_W-1:0]      sync1;
    logic [asbla_pkg::DATA_W-1:0]      sync2;
    logic [asbla_pkg::DATA_W-1:0]      sync3;
  } asbla_regs_type;

  asbla_regs_type r;
  asbla_regs_type next_r;

  function automatic logic [asbla_pkg::CNT_W-1:0] cycles(input int n);
    cycles = asbla_pkg::CNT_W'(n - 1);
  endfunction

  // Merge only the lanes that were read
  function automatic logic [asbla_pkg::DATA_W-1:0] laneMerge(
    input logic [asbla_pkg::DATA_W-1:0] d,
    input logic [1:0]                   en);
    laneMerge = {en[1] ? d[15:8] : 8'h00, en[0] ? d[7:0] : 8'h00};
  endfunction

  always_comb
  begin
    next_r = r;
    next_r.sync1 = memDataIn;
    next_r.sync2 = r.sync1;
    next_r.sync3 = r.sync2;
    next_r.rspValid = 1'b0;
    case (r.state)
      asbla_pkg::ST_POWER_UP:
      begin
        if (r.cnt == '0)
          next_r.state = asbla_pkg::ST_IDLE;
        else
          next_r.cnt = r.cnt - 1'b1;
      end
      asbla_pkg::ST_IDLE:
      begin
        if (reqValid)
        begin
          // Address and lanes settle one cycle before select falls
          next_r.addr = reqAddr;
          next_r.wdata = reqWdata;
          next_r.laneEn = reqByteEn;
          if (reqWrite)
          begin
            next_r.oe_n = 1'b1;
            next_r.state = asbla_pkg::ST_WRITE_SETUP;
          end
          else
          begin
            // One address setup cycle, the access time, then three sync flops
            next_r.cnt = cycles(asbla_pkg::READ_ACCESS_CYCLES + 4);
            next_r.we_n = 1'b1;
            next_r.state = asbla_pkg::ST_READ_WAIT;
          end
        end
      end
      asbla_pkg::ST_WRITE_SETUP:
      begin
        // Both select and strobe fall together; data driven from now on
        next_r.cs_n = 1'b0;
        next_r.we_n = 1'b0;
        next_r.dataOe = r.laneEn;
        next_r.cnt = cycles(asbla_pkg::WRITE_PULSE_CYCLES + 1);
        next_r.state = asbla_pkg::ST_WRITE_PULSE;
      end
      asbla_pkg::ST_WRITE_PULSE:
      begin
        if (r.cnt == '0)
        begin
          // Strobe rises first; select and data stay one more cycle
          next_r.we_n = 1'b1;
          next_r.state = asbla_pkg::ST_WRITE_END;
        end
        else
          next_r.cnt = r.cnt - 1'b1;
      end
      asbla_pkg::ST_WRITE_END:
      begin
        next_r.cs_n = 1'b1;
        next_r.dataOe = 2'h0;
        next_r.rspValid = 1'b1;
        next_r.state = asbla_pkg::ST_IDLE;
      end
      asbla_pkg::ST_READ_WAIT:
      begin
        if (r.cnt == '0)
        begin
          next_r.rdata = laneMerge(r.sync3, r.laneEn);
          next_r.cs_n = 1'b1;
          next_r.oe_n = 1'b1;
          next_r.state = asbla_pkg::ST_READ_END;
        end
        else
        begin
          // Select falls one cycle after the address has settled
          next_r.cs_n = 1'b0;
          next_r.oe_n = 1'b0;
          next_r.cnt = r.cnt - 1'b1;
        end
      end
      asbla_pkg::ST_READ_END:
      begin
        // One idle cycle lets the memory float before any write drives
        next_r.rspValid = 1'b1;
        next_r.state = asbla_pkg::ST_IDLE;
      end
      default:
        next_r.state = asbla_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      r <= '0;
      r.state <= asbla_pkg::ST_POWER_UP;
      r.cnt <= cycles(asbla_pkg::POWER_UP_CYCLES);
      r.cs_n <= 1'b1;
      r.oe_n <= 1'b1;
      r.we_n <= 1'b1;
      r.laneEn <= 2'h0;
    end
    else
      r <= next_r;
  end

  assign reqReady = (r.state == asbla_pkg::ST_IDLE);
  assign rspValid = r.rspValid;
  assign rspRdata = r.rdata;
  assign memAddr = r.addr;
  assign chipSel_n = r.cs_n;
  assign outDrive_n = r.oe_n;
  assign writeStrobe_n = r.we_n;
  // Lanes are enabled only while selected
  assign low_byte_sel_n = r.cs_n | ~r.laneEn[0];
  assign high_byte_sel_n = r.cs_n | ~r.laneEn[1];
  assign memDataOut = r.wdata;
  assign memDataOe = r.dataOe;

  AST_WRITE_NEEDS_BOTH: assert property (@(posedge clk) disable iff (!reset_n)
    !writeStrobe_n |-> !chipSel_n) else $error("strobe low without select");
  AST_READ_STROBE_HIGH: assert property (@(posedge clk) disable iff (!reset_n)
    (!outDrive_n && !chipSel_n) |-> writeStrobe_n) else $error("strobe low in read");
  AST_PULSE_LENGTH: assert property (@(posedge clk) disable iff (!reset_n)
    $fell(writeStrobe_n) |-> !writeStrobe_n [*2]) else $error("write pulse too short");
  AST_DATA_HOLD: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(writeStrobe_n) |-> !chipSel_n && memDataOe == $past(memDataOe)
      && $stable(memDataOut)) else $error("data not held at write end");
  AST_NO_DRIVE_IN_READ: assert property (@(posedge clk) disable iff (!reset_n)
    !outDrive_n |-> memDataOe == 2'h0) else $error("bus contention in read");
  AST_ADDR_STABLE: assert property (@(posedge clk) disable iff (!reset_n)
    !chipSel_n |-> $stable(memAddr)) else $error("address moved while selected");
  AST_POWER_WAIT: assert property (@(posedge clk)
    $rose(reset_n) |-> chipSel_n [*8]) else $error("access before settling");
  AST_WRITE_LANES: assert property (@(posedge clk) disable iff (!reset_n)
    !writeStrobe_n |-> memDataOe == ~{high_byte_sel_n, low_byte_sel_n})
    else $error("lane enables differ from driven lanes");
  AST_RESPONSE: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(chipSel_n) |-> ##[0:1] rspValid)
    else $error("no response after access");

  COV_WRITE: cover property (@(posedge clk) disable iff (!reset_n)
    $fell(writeStrobe_n) ##[1:5] rspValid);
  COV_READ: cover property (@(posedge clk) disable iff (!reset_n)
    $fell(outDrive_n) ##[1:8] rspValid);
  COV_LOW_ONLY: cover property (@(posedge clk) disable iff (!reset_n)
    !chipSel_n && !low_byte_sel_n && high_byte_sel_n);
endmodule

// ---- src/asbla_pkg.sv ----
// Package for the static memory controller: pin widths and timing counts.
// Assumes a 10 MHz system clock.
package asbla_pkg;
  localparam int ADDR_W = 18;
  localparam int DATA_W = 16;
  localparam int CLK_PERIOD_NS = 100;
  // Settling time after supply is up, in microseconds
  localparam int POWER_UP_US = 1;
  localparam int POWER_UP_CYCLES = (POWER_UP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Strobe-to-float delay and data setup, in nanoseconds
  localparam int WRITE_TO_FLOAT_DELAY_NS = 8;
  localparam int DATA_SETUP_TO_WRITE_END_NS = 8;
  localparam int WRITE_PULSE_NS = WRITE_TO_FLOAT_DELAY_NS + DATA_SETUP_TO_WRITE_END_NS;
  localparam int WRITE_PULSE_RAW = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRITE_PULSE_CYCLES = (WRITE_PULSE_RAW < 1) ? 1 : WRITE_PULSE_RAW;
  // Read access time, in nanoseconds
  localparam int READ_ACCESS_NS = 20;
  localparam int READ_ACCESS_RAW = (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int READ_ACCESS_CYCLES = (READ_ACCESS_RAW < 1) ? 1 : READ_ACCESS_RAW;
  localparam int CNT_W = 8;

  typedef enum logic [2:0] {
    ST_POWER_UP,
    ST_IDLE,
    ST_WRITE_SETUP,
    ST_WRITE_PULSE,
    ST_WRITE_END,
    ST_READ_WAIT,
    ST_READ_END
  } asbla_state_type;
endpackage

// ---- verification/asbla_mem_model.sv ----
// Behavioural 256K x 16 static memory on the far side of the controller.
// Assumes the controller's pins; unselected or floating lanes show a changing pattern.
`timescale 1ns/100ps
module asbla_mem_model
#(
  parameter int ACCESS_NS = 20
)
(
  input  wire logic        clk,
  input  wire logic [17:0] addr,
  input  wire logic        chipSel_n,
  input  wire logic        outDrive_n,
  input  wire logic        writeStrobe_n,
  input  wire logic        low_byte_sel_n,
  input  wire logic        high_byte_sel_n,
  input  wire logic [15:0] wrData,
  input  wire logic [1:0]  wrOe,
  output logic [15:0]      rdData
);
  logic [15:0] mem [0:262143];
  logic [15:0] held = 16'h0000;
  logic [1:0]  drive;
  logic [15:0] bus;
  logic [1:0]  lanes;
  assign lanes = ~{high_byte_sel_n, low_byte_sel_n};
  // Drive only while reading and enabled; floating otherwise
  assign drive = {2{~chipSel_n & ~outDrive_n & writeStrobe_n}} & lanes;
  always @*
  begin
    bus[15:8] = drive[1] ? mem[addr][15:8] : ~held[15:8];
    bus[7:0] = drive[0] ? mem[addr][7:0] : ~held[7:0];
  end
  assign #(ACCESS_NS) rdData = bus;
  always @(posedge clk) held <= rdData;
  // Write window is the overlap of select and strobe; output drive ignored
  always @*
  begin
    if (!chipSel_n && !writeStrobe_n)
    begin
      if (lanes[0] && wrOe[0]) mem[addr][7:0] = wrData[7:0];
      if (lanes[1] && wrOe[1]) mem[addr][15:8] = wrData[15:8];
    end
  end
endmodule

// ---- verification/asbla_ctrl_tb.sv ----
// Self-checking bench for the static memory controller.
// Assumes the behavioural memory model as the far side.
`timescale 1ns/100ps
module asbla_ctrl_tb;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        reqValid = 1'b0;
  logic        reqWrite = 1'b0;
  logic [17:0] reqAddr = 18'h00000;
  logic [15:0] reqWdata = 16'h0000;
  logic [1:0]  reqByteEn = 2'h0;
  logic        reqReady, rspValid, cs_n, oe_n, we_n, lb_n, hb_n;
  logic [15:0] rspRdata, memDataIn, memDataOut, rd;
  logic [17:0] memAddr;
  logic [1:0]  memDataOe;
  int          failCount = 0;
  int          nCompared = 0;
  always #50 clk = ~clk;
  asbla_ctrl dut_u (.clk(clk), .reset_n(reset_n), .reqValid(reqValid), .reqReady(reqReady),
    .reqWrite(reqWrite), .reqAddr(reqAddr), .reqWdata(reqWdata), .reqByteEn(reqByteEn),
    .rspValid(rspValid), .rspRdata(rspRdata), .memAddr(memAddr), .chipSel_n(cs_n),
    .outDrive_n(oe_n), .writeStrobe_n(we_n), .low_byte_sel_n(lb_n), .high_byte_sel_n(hb_n),
    .memDataIn(memDataIn), .memDataOut(memDataOut), .memDataOe(memDataOe));
  asbla_mem_model mem_u (.clk(clk), .addr(memAddr), .chipSel_n(cs_n), .outDrive_n(oe_n),
    .writeStrobe_n(we_n), .low_byte_sel_n(lb_n), .high_byte_sel_n(hb_n),
    .wrData(memDataOut), .wrOe(memDataOe), .rdData(memDataIn));
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    nCompared++;
    if (got !== exp)
    begin
      failCount++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    if (failCount == 0 && nCompared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic access(input logic w, input logic [17:0] a, input logic [15:0] d,
                        input logic [1:0] be, output logic [15:0] r);
    int n;
    @(posedge clk);
    reqValid <= 1'b1;
    reqWrite <= w;
    reqAddr <= a;
    reqWdata <= d;
    reqByteEn <= be;
    n = 0;
    do begin @(negedge clk); n++; end while (reqReady !== 1'b1 && n < 40);
    @(posedge clk);
    reqValid <= 1'b0;
    n = 0;
    do begin @(negedge clk); n++; end while (rspValid !== 1'b1 && n < 20);
    check({15'h0000, rspValid}, 16'h0001);
    r = rspRdata;
  endtask
  task automatic test_reset;
    @(negedge clk);
    check({13'h0000, cs_n, we_n, reqReady}, 16'h0006);
    check({14'h0000, memDataOe}, 16'h0000);
    @(posedge clk);
    reset_n <= 1'b1;
    repeat (5)
    begin
      @(negedge clk);
      check({15'h0000, reqReady}, 16'h0000);
    end
  endtask
  task automatic test_full;
    access(1'b1, 18'h3ffff, 16'ha55a, 2'h3, rd);
    access(1'b0, 18'h3ffff, 16'h0000, 2'h3, rd);
    check(rd, 16'ha55a);
  endtask
  task automatic test_lanes;
    access(1'b1, 18'h3ffff, 16'h1234, 2'h1, rd);
    access(1'b0, 18'h3ffff, 16'h0000, 2'h3, rd);
    check(rd, 16'ha534);
    access(1'b0, 18'h3ffff, 16'h0000, 2'h2, rd);
    check(rd, 16'ha500);
  endtask
  task automatic test_b2b;
    access(1'b1, 18'h00000, 16'hbeef, 2'h3, rd);
    access(1'b1, 18'h00001, 16'hc0de, 2'h3, rd);
    access(1'b0, 18'h00000, 16'h0000, 2'h3, rd);
    check(rd, 16'hbeef);
    access(1'b0, 18'h00001, 16'h0000, 2'h3, rd);
    check(rd, 16'hc0de);
  endtask
  initial
  begin
    #(3000 * 100);
    failCount++;
    conclude();
  end
  initial
  begin
    repeat (2) @(posedge clk);
    test_reset();
    test_full();
    test_lanes();
    test_b2b();
    conclude();
  end
endmodule
